/* src/adctm_top.sv */
// Converter timing and auxiliary negative-input select registers on APB
//
// Summary of operation
// - Sample time equals field value, 0..31
// - Clock period is Tcy times divider plus one
// - Aux select bits 15..11 read zero
// - All sample B negative codes reserved in 12-bit
// - Codes 00/01 connect negative reference to 1..3
// - Small part: code 10 gives 6,7,NC
// - Large part: code 10 gives 6,7,8
// - Large part: code 11 gives 9,NC,NC
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module adctm_top
(
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Converter context
	input  wire logic               conversion_trigger_source,
	input  wire logic               twelve_bit_mode_sel,
	input  wire logic               sample_start,
	// Converter controls
	output adctm_pkg::adctm_timing_t timing,
	output adctm_pkg::adctm_route_t  route_b,
	output logic                    tad_tick,
	output logic                    sample_done
);
	import adctm_pkg::*;

	logic [15:0] timing_q, timing_d;
	logic [15:0] auxsel_q, auxsel_d;
	logic [7:0]  tcy_cnt_q, tcy_cnt_d;
	logic [4:0]  samp_cnt_q, samp_cnt_d;
	logic        sampling_q, sampling_d;
	logic        done_q, done_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pslverr_q, pslverr_d;

	// APB decode
	wire access   = psel & penable;
	wire wr_en    = access & pwrite;
	wire hit_tim  = paddr == ADCTM_TIMING_OFF;
	wire hit_aux  = paddr == ADCTM_AUXSEL_OFF;
	wire hit_sts  = paddr == ADCTM_STATUS_OFF;
	wire hit_trg  = paddr == ADCTM_TRIGGER_OFF;
	wire hit_any  = hit_tim | hit_aux | hit_sts | hit_trg;
	wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Field views
	wire       src_rc   = timing_q[ADCTM_SRC_BIT];
	wire [4:0] samc     = timing_q[ADCTM_SAMC_LSB +: ADCTM_SAMC_W];
	wire [7:0] divf     = timing_q[ADCTM_DIV_LSB +: ADCTM_DIV_W];
	wire       div_rsvd = divf > ADCTM_DIV_MAX;
	wire [1:0] negb     = auxsel_q[ADCTM_NEGB_LSB +: ADCTM_NEGB_W];

	// Bits a write may change: enabled lanes and implemented bits
	wire [15:0] tim_wbits = lane_mask & ADCTM_TIMING_WMASK;
	wire [15:0] aux_wbits = lane_mask & ADCTM_AUXSEL_WMASK;

	// Register writes, masked by lanes and implemented bits
	assign timing_d = (wr_en & hit_tim)
		? (timing_q & ~tim_wbits) | (pwdata[15:0] & tim_wbits)
		: timing_q;
	assign auxsel_d = (wr_en & hit_aux)
		? (auxsel_q & ~aux_wbits) | (pwdata[15:0] & aux_wbits)
		: auxsel_q;

	// Read mux; unimplemented bits are zero by masking
	wire [31:0] rd_tim = {16'h0000, timing_q & ADCTM_TIMING_WMASK};
	wire [31:0] rd_aux = {16'h0000, auxsel_q & ADCTM_AUXSEL_WMASK};
	wire [4:0]  sts_bits = {route_b.reserved, div_rsvd, done_q, sampling_q, src_rc};
	wire [31:0] rd_sts   = {27'h0000000, sts_bits};
	assign prdata_d = hit_tim ? rd_tim :
		hit_aux ? rd_aux :
		hit_sts ? rd_sts : 32'h00000000;

	// Unmapped address seen in setup flags the following access
	assign pslverr_d = psel & ~penable & ~hit_any;

	// Tad enable: divider counts Tcy = pclk; held when RC source selected
	wire       tcy_wrap    = tcy_cnt_q >= divf;
	wire [7:0] tcy_cnt_inc = tcy_cnt_q + 8'h01;
	assign tcy_cnt_d = (src_rc | tcy_wrap) ? 8'h00 : tcy_cnt_inc;
	assign tad_tick  = src_rc ? 1'b1 : tcy_wrap;

	// Auto sample timer, armed only when the trigger source is automatic
	wire       auto_en   = conversion_trigger_source;
	wire       trg_wr    = wr_en & hit_trg;
	wire       start_ok  = auto_en & ~sampling_q & (sample_start | trg_wr);
	wire       samc_zero = samc == 5'h00;
	wire [4:0] samc_last = samc - 5'h01;
	wire       cnt_tick  = sampling_q & tad_tick;
	wire       samp_end  = cnt_tick & (samc_zero | (samp_cnt_q >= samc_last));
	assign sampling_d = start_ok ? ~samc_zero : (samp_end ? 1'b0 : sampling_q);
	assign samp_cnt_d = start_ok ? 5'h00 :
		(cnt_tick & ~samp_end) ? samp_cnt_q + 5'h01 : samp_cnt_q;
	assign done_d = samp_end | (start_ok & samc_zero);

	// Sample B negative routing decode
	always_comb begin
		route_b.ch1      = ADCTM_NEG_VREF;
		route_b.ch2      = ADCTM_NEG_VREF;
		route_b.ch3      = ADCTM_NEG_VREF;
		route_b.reserved = 1'b0;
		if (twelve_bit_mode_sel) begin
			route_b.ch1      = ADCTM_NEG_NC;
			route_b.ch2      = ADCTM_NEG_NC;
			route_b.ch3      = ADCTM_NEG_NC;
			route_b.reserved = 1'b1;
		end else begin
			unique case (negb)
				2'h0, 2'h1: begin
					route_b.ch1 = ADCTM_NEG_VREF;
					route_b.ch2 = ADCTM_NEG_VREF;
					route_b.ch3 = ADCTM_NEG_VREF;
				end
				2'h2: begin
					route_b.ch1 = ADCTM_NEG_AN6;
					route_b.ch2 = ADCTM_NEG_AN7;
					route_b.ch3 = ADCTM_LARGE_VARIANT ? ADCTM_NEG_AN8 : ADCTM_NEG_NC;
				end
				2'h3: begin
					if (ADCTM_LARGE_VARIANT) begin
						route_b.ch1 = ADCTM_NEG_AN9;
						route_b.ch2 = ADCTM_NEG_NC;
						route_b.ch3 = ADCTM_NEG_NC;
					end else begin
						route_b.ch1      = ADCTM_NEG_NC;
						route_b.ch2      = ADCTM_NEG_NC;
						route_b.ch3      = ADCTM_NEG_NC;
						route_b.reserved = 1'b1;
					end
				end
			endcase
		end
	end

	// Timing outputs
	assign timing.conv_clock_source_sel = src_rc;
	assign timing.auto_sample_time      = samc;
	assign timing.conv_clock_divider    = divf;

	// APB answers in its access cycle
	assign pready      = 1'b1;
	assign prdata      = prdata_q;
	assign pslverr     = pslverr_q;
	assign sample_done = done_q;

	// Timing register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timing_q <= ADCTM_TIMING_RST;
		end else begin
			timing_q <= timing_d;
		end
	end

	// Aux select register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auxsel_q <= ADCTM_AUXSEL_RST;
		end else begin
			auxsel_q <= auxsel_d;
		end
	end

	// Conversion clock divider count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcy_cnt_q <= 8'h00;
		end else begin
			tcy_cnt_q <= tcy_cnt_d;
		end
	end

	// Auto sample timer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_cnt_q <= 5'h00;
			sampling_q <= 1'b0;
		end else begin
			samp_cnt_q <= samp_cnt_d;
			sampling_q <= sampling_d;
		end
	end

	// Sample done pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	// Read data captured in setup, stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (psel & ~penable) begin
			prdata_q <= prdata_d;
		end
	end

	// Error flag, high only in the access of an unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= pslverr_d;
		end
	end
endmodule

/* src/adctm_pkg.sv */
// Package for the converter timing and auxiliary negative-input select block
package adctm_pkg;
	// Register byte offsets on APB
	localparam logic [11:0] ADCTM_TIMING_OFF   = 12'h000;
	localparam logic [11:0] ADCTM_AUXSEL_OFF   = 12'h004;
	localparam logic [11:0] ADCTM_STATUS_OFF   = 12'h008;
	localparam logic [11:0] ADCTM_TRIGGER_OFF  = 12'h00c;
	// Timing register field positions
	localparam int ADCTM_SRC_BIT     = 15;
	localparam int ADCTM_SAMC_LSB    = 8;
	localparam int ADCTM_SAMC_W      = 5;
	localparam int ADCTM_DIV_LSB     = 0;
	localparam int ADCTM_DIV_W       = 8;
	// Aux select field positions
	localparam int ADCTM_NEGB_LSB    = 9;
	localparam int ADCTM_NEGB_W      = 2;
	localparam int ADCTM_SELB_BIT    = 8;
	localparam int ADCTM_SELA_BIT    = 0;
	localparam int ADCTM_NEGA_LSB    = 1;
	// Reset values
	localparam logic [15:0] ADCTM_TIMING_RST = 16'h0000;
	localparam logic [15:0] ADCTM_AUXSEL_RST = 16'h0000;
	// Writable masks
	localparam logic [15:0] ADCTM_TIMING_WMASK = 16'h9fff;
	localparam logic [15:0] ADCTM_AUXSEL_WMASK = 16'h0607;
	localparam logic [7:0]  ADCTM_DIV_MAX      = 8'h3f;
	// Variant: smaller part routes fewer negative inputs
	localparam bit ADCTM_LARGE_VARIANT = 1'b1;
	// Negative input source per channel
	typedef enum logic [2:0] {
		ADCTM_NEG_NC    = 3'h0,
		ADCTM_NEG_VREF  = 3'h1,
		ADCTM_NEG_AN6   = 3'h2,
		ADCTM_NEG_AN7   = 3'h3,
		ADCTM_NEG_AN8   = 3'h4,
		ADCTM_NEG_AN9   = 3'h5
	} adctm_neg_t;
	// Resolved timing controls
	typedef struct packed {
		logic       conv_clock_source_sel;
		logic [4:0] auto_sample_time;
		logic [7:0] conv_clock_divider;
	} adctm_timing_t;
	// Negative routing for channels 1..3 during sample B
	typedef struct packed {
		adctm_neg_t ch1;
		adctm_neg_t ch2;
		adctm_neg_t ch3;
		logic       reserved;
	} adctm_route_t;
endpackage

/* verification/adctm_checker.sv */
// Checker for the converter timing and aux select block
`timescale 1ns/10ps
module adctm_checker
	import adctm_pkg::*;
(
	// APB side
	input logic pclk, presetn, psel, penable, pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata, prdata,
	input logic [3:0] pstrb,
	// Converter side
	input logic twelve_bit_mode_sel, tad_tick, sample_done,
	input adctm_pkg::adctm_timing_t timing,
	input adctm_pkg::adctm_route_t route_b
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of the sample B negative code
	logic [1:0] code_q;
	wire wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) code_q <= 2'h0;
		else if (wr && paddr == 12'h004 && pstrb[1]) code_q <= pwdata[10:9];
	end
	chk_rc_tick:
	assert property (timing.conv_clock_source_sel && $stable(timing) |-> tad_tick) else $error("rc tick");
	chk_timing_write:
	assert property (wr && paddr == 12'h000 && &pstrb[1:0]
		|=> timing == {$past(pwdata[15]), $past(pwdata[12:0])}) else $error("timing write");
	chk_div_tick:
	assert property ((!timing.conv_clock_source_sel && timing.conv_clock_divider == 8'h01)[*2]
		##0 tad_tick |=> !tad_tick || timing.conv_clock_source_sel) else $error("div tick");
	chk_aux_upper:
	assert property (psel && penable && !pwrite && paddr == 12'h004 |-> prdata[15:11] == 5'h00)
		else $error("aux upper");
	chk_twelve_res:
	assert property (twelve_bit_mode_sel |-> route_b == {{3{ADCTM_NEG_NC}}, 1'b1}) else $error("12b");
	chk_route_vref:
	assert property (!twelve_bit_mode_sel && !code_q[1] |-> route_b == {{3{ADCTM_NEG_VREF}}, 1'b0})
		else $error("vref");
	chk_route_six:
	assert property (!twelve_bit_mode_sel && code_q == 2'h2
		|-> route_b == {ADCTM_NEG_AN6, ADCTM_NEG_AN7, ADCTM_NEG_AN8, 1'b0}) else $error("an6");
	chk_route_nine:
	assert property (!twelve_bit_mode_sel && code_q == 2'h3
		|-> route_b == {ADCTM_NEG_AN9, ADCTM_NEG_NC, ADCTM_NEG_NC, 1'b0}) else $error("an9");
	// Main scenarios
	cover property (route_b.ch1 == ADCTM_NEG_AN9);
	cover property (sample_done);
	cover property (tad_tick && !timing.conv_clock_source_sel);
endmodule
bind adctm_top adctm_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pstrb(pstrb), .twelve_bit_mode_sel(twelve_bit_mode_sel), .tad_tick(tad_tick),
	.sample_done(sample_done), .timing(timing), .route_b(route_b));

/* verification/adctm_tb_top.sv */
// Bench for the converter timing and aux select block
`timescale 1ns/10ps
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module adctm_tb_top;
	import adctm_pkg::*;
	logic pclk=0, presetn=0, psel=0, penable=0, pwrite=0, trig=0, twelve=0, start=0;
	logic pready, pslverr, err, tad_tick, sample_done;
	logic [3:0] pstrb=4'hf;
	logic [11:0] paddr=0;
	logic [31:0] pwdata=0, prdata, rd, d;
	logic [7:0] lf=8'h1c;
	adctm_timing_t timing;
	adctm_route_t route_b;
	int n_errors=0, compares=0, cyc=0, k;
	adctm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conversion_trigger_source(trig),
		.twelve_bit_mode_sel(twelve), .sample_start(start), .timing(timing),
		.route_b(route_b), .tad_tick(tad_tick), .sample_done(sample_done));
	initial forever #12.5 pclk = ~pclk;
	// Cut a hang short
	always @(posedge pclk) if (++cyc > 4000) begin n_errors++; wrap_up; end
	function automatic logic [7:0] nx(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Expected routing, larger variant
	function automatic adctm_route_t er(logic [1:0] c, logic t);
		if (t) return {{3{ADCTM_NEG_NC}}, 1'b1};
		if (c == 2'd2) return {ADCTM_NEG_AN6, ADCTM_NEG_AN7, ADCTM_NEG_AN8, 1'b0};
		if (c == 2'd3) return {ADCTM_NEG_AN9, ADCTM_NEG_NC, ADCTM_NEG_NC, 1'b0};
		return {{3{ADCTM_NEG_VREF}}, 1'b0};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wrap_up;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 0);
		`CHK("timing reset", 32'h0, rd)
		`CHK("mapped err", 1'b0, err)
		`CHK("route reset", er(0, 0), route_b)
		apb(0, 12'h010, 0);
		`CHK("unmapped read", 32'h0, rd)
		`CHK("unmapped err", 1'b1, err)
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			d = i ? {4{lf}} : 32'hffffffff;
			apb(1, 12'h000, d);
			apb(0, 12'h000, 0);
			`CHK("timing read", {16'h0, d[15:0] & 16'h9fff}, rd)
			`CHK("timing out", {d[15], d[12:0]}, timing)
		end
		pstrb <= 4'h1;
		apb(1, 12'h000, 32'h0000ffff);
		pstrb <= 4'hf;
		apb(0, 12'h000, 0);
		`CHK("lane write", {16'h0, d[15:8] & 8'h9f, 8'hff}, rd)
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h000, i == 0 ? 32'h0 : i == 1 ? 32'h80ff : 32'h1);
			repeat (300) @(negedge pclk);
			k = 0;
			repeat (20) @(negedge pclk) k += tad_tick;
			`CHK("tick count", i == 2 ? 10 : 20, k)
		end
		$display("timing test done");
		for (int c = 0; c < 8; c++) begin
			lf = nx(lf);
			d = {lf, lf, lf[7:3], c[1:0], lf[0], lf};
			twelve <= c[2];
			apb(1, 12'h004, d);
			apb(0, 12'h004, 0);
			`CHK("aux read", {16'h0, d[15:0] & 16'h0607}, rd)
			`CHK("route", er(c[1:0], c[2]), route_b)
		end
		twelve <= 0;
		$display("aux test done");
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h000, i == 1 ? 32'h8200 : 32'h8000);
			trig <= (i < 2);
			@(posedge pclk) start <= 1;
			@(posedge pclk) start <= 0;
			k = 0;
			for (int j = 1; j < 9; j++) begin
				@(negedge pclk);
				if (sample_done === 1'b1 && k == 0) k = j;
			end
			`CHK("done cycle", i == 0 ? 1 : i == 1 ? 3 : 0, k)
		end
		apb(1, 12'h000, 32'h00000040);
		apb(0, 12'h008, 0);
		`CHK("status", 32'h8, rd)
		trig <= 1;
		apb(1, 12'h00c, 0);
		@(negedge pclk);
		`CHK("trigger done", 1'b1, sample_done)
		$display("sample test done");
		@(posedge pclk) presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h004, 0);
		`CHK("aux after reset", 32'h0, rd)
		`CHK("route after reset", er(0, 0), route_b)
		$display("reset test done");
		wrap_up;
	end
endmodule
